/* include/teach_cfg_pkg.sv */
// Constants, types and register map of the teach and output control block
//==========================================================================
// Summary of operation
// - Delivery state: both outputs one static point at range end, 400/1600 mm.
// - Yellow LED belongs to first output, blue to second; each shows it.
// - Hold of two seconds enters teach mode, first output, yellow at 1 Hz.
// - In teach mode a short press swaps outputs; selected LED blinks 1 Hz.
// - Hold 2 to 7 s teaches one point; 7 to 12 s a window.
// - Hold 7 to 12 s captures first window point; LEDs alternate 3 Hz.
// - After release stays in teach, still alternating, awaiting point two.
// - A short press captures point two and stores the window between both.
// - Window points at least 40 mm (short) or 160 mm (long) apart.
// - Failed teach: green and selected LED blink 8 Hz until a good teach or a hold over 12 s.
// - Factory function: first output normally open, second normally closed.
// - Hold over 12 s inverts selected function; output frozen meanwhile.
// - Inverting a function toggles that output to its opposite state.
// - During changeover LEDs alternate 3 Hz; then lit for open, dark closed.
// - Sync mode: up to six sensors fire together, about 20 ms added.
// - The sensors create the shared sync pulse themselves, no generator.
// - Multiplex: up to four sensors take turns; passive ones freeze outputs.
// - Multiplex response is n times single response plus 25 ms.
// - Button held over 5 s at power-on restores factory; fast blink after.
package teach_cfg_pkg;
  //==========================================================================
  // Clock and timebase
  localparam int MCLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = MCLK_HZ / MS_PER_S;
  localparam int HW = 14;
  localparam int DW = 11;
  localparam int PW = 8;
  localparam int NVW = 48;
  localparam int MAX_SYNC = 6;
  localparam int MAX_MUX = 4;
  //==========================================================================
  // Button hold thresholds
  localparam int HOLD_TEACH_S = 2;
  localparam int HOLD_WIN_S = 7;
  localparam int HOLD_FLIP_S = 12;
  localparam int HOLD_FACT_S = 5;
  localparam logic [HW-1:0] TEACH_MS = HW'(HOLD_TEACH_S * MS_PER_S);
  localparam logic [HW-1:0] WIN_MS = HW'(HOLD_WIN_S * MS_PER_S);
  localparam logic [HW-1:0] FLIP_MS = HW'(HOLD_FLIP_S * MS_PER_S);
  localparam logic [HW-1:0] FACT_MS = HW'(HOLD_FACT_S * MS_PER_S);
  localparam logic [HW-1:0] SHOW_MS = 14'h07D0;
  localparam logic [HW-1:0] FACT_SHOW_MS = 14'h03E8;
  //==========================================================================
  // Blink rates
  localparam int SLOW_HZ = 1;
  localparam int MID_HZ = 3;
  localparam int FAST_HZ = 8;
  localparam int BL_SLOW = 0;
  localparam int BL_MID = 1;
  localparam int BL_FAST = 2;
  //==========================================================================
  // Distances in mm
  localparam logic [DW-1:0] SHORT_END_MM = 11'h190;
  localparam logic [DW-1:0] LONG_END_MM = 11'h640;
  localparam logic [DW-1:0] SHORT_LOW_MM = 11'h032;
  localparam logic [DW-1:0] LONG_LOW_MM = 11'h096;
  localparam logic [DW-1:0] SHORT_SEP_MM = 11'h028;
  localparam logic [DW-1:0] LONG_SEP_MM = 11'h0A0;
  localparam logic [1:0] NC_DEFAULT = 2'h2;
  //==========================================================================
  // Pulse scheduling in ms
  localparam logic [PW-1:0] MEAS_MS = 8'h19;
  localparam logic [PW-1:0] SYNC_DLY_MS = 8'h14;
  localparam logic [PW-1:0] MUX_GUARD_MS = 8'h19;
  localparam logic [1:0] MODE_ALONE = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_MUX = 2'h2;
  //==========================================================================
  // Register map
  localparam int AW = 4;
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_STAT = 4'h4;
  localparam logic [AW-1:0] REG_PT1 = 4'h8;
  localparam logic [AW-1:0] REG_PT2 = 4'hC;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RANGE_BIT = 2;
  localparam int CTRL_SLOT_LSB = 3;
  localparam int CTRL_NET_LSB = 5;
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam int PT_HI_LSB = 16;
  localparam int STAT_ST_LSB = 8;
  //==========================================================================
  // Types
  typedef enum logic [7:0] {
    ST_INIT = 8'h01, ST_POR = 8'h02, ST_RUN = 8'h04, ST_SEL = 8'h08,
    ST_WIN = 8'h10, ST_FLIP = 8'h20, ST_ERR = 8'h40, ST_FACT = 8'h80
  } teach_st_t;
  typedef enum logic [1:0] {
    HC_SHORT = 2'h0, HC_ONE = 2'h1, HC_WIN = 2'h2, HC_LONG = 2'h3
  } hold_cls_t;
endpackage : teach_cfg_pkg

/* rtl/teach_timebase.sv */
// Millisecond tick and LED blink phase generator
`timescale 1ns/1ps
module teach_timebase #(
  parameter int CYC_PER_MS = teach_cfg_pkg::CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic rst,
  output logic ms_tick,
  output logic [2:0] blink
);
  import teach_cfg_pkg::*;

  localparam int HALF_MS [3] = '{MS_PER_S / (2 * SLOW_HZ),
                                 MS_PER_S / (2 * MID_HZ),
                                 MS_PER_S / (2 * FAST_HZ)};

  generate
    if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) begin : g_bad
      $error("CYC_PER_MS out of range");
    end
  endgenerate

  logic [15:0] div_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_ff <= 16'h0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (div_ff == 16'(CYC_PER_MS - 1));
      div_ff <= (div_ff == 16'(CYC_PER_MS - 1)) ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  // One counter per rate, each toggling its phase at the half period
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_blink
      logic [9:0] cnt_ff;
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cnt_ff <= 10'h000;
          blink[gi] <= 1'b0;
        end else if (ms_tick) begin
          if (cnt_ff == 10'(HALF_MS[gi] - 1)) begin
            cnt_ff <= 10'h000;
            blink[gi] <= ~blink[gi];
          end else begin
            cnt_ff <= cnt_ff + 10'h001;
          end
        end
      end
    end
  endgenerate
endmodule : teach_timebase

/* rtl/teach_output_ctrl.sv */
// Teach button, indicator, output function and sync line control
`timescale 1ns/1ps
module teach_output_ctrl #(
  parameter int CYC_PER_MS = teach_cfg_pkg::CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic button,
  input wire logic meas_valid,
  input wire logic meas_ok,
  input wire logic [teach_cfg_pkg::DW-1:0] meas_dist,
  input wire logic nvm_valid,
  input wire logic [teach_cfg_pkg::NVW-1:0] nvm_rd_data,
  input wire logic [teach_cfg_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic shared_pulse_coord_line_in,
  output logic [31:0] reg_rdata,
  output logic tx_fire,
  output logic first_switch_output,
  output logic second_switch_output,
  output logic led_yellow,
  output logic led_blue,
  output logic led_green,
  output logic shared_pulse_coord_line_out,
  output logic shared_pulse_coord_line_oe,
  output logic nvm_wr,
  output logic [teach_cfg_pkg::NVW-1:0] nvm_wr_data
);
  import teach_cfg_pkg::*;

  generate
    if (CYC_PER_MS < 1) begin : g_bad
      $error("CYC_PER_MS must be positive");
    end
  endgenerate

  //==========================================================================
  // Timebase
  logic ms_tick;
  logic [2:0] blink;

  teach_timebase #(.CYC_PER_MS(CYC_PER_MS)) u_timebase (
    .mclk(mclk),
    .rst(rst),
    .ms_tick(ms_tick),
    .blink(blink)
  );

  //==========================================================================
  // Control register
  logic [7:0] ctrl_ff;
  logic [1:0] mode;
  logic range_long;
  logic [1:0] slot;
  logic [2:0] net;

  assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];
  assign range_long = ctrl_ff[CTRL_RANGE_BIT];
  assign slot = ctrl_ff[CTRL_SLOT_LSB +: 2];
  assign net = ctrl_ff[CTRL_NET_LSB +: 3];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_ff <= reg_wdata[7:0];
    end
  end

  logic [DW-1:0] end_mm;
  logic [DW-1:0] low_mm;
  logic [DW-1:0] sep_mm;

  assign end_mm = range_long ? LONG_END_MM : SHORT_END_MM;
  assign low_mm = range_long ? LONG_LOW_MM : SHORT_LOW_MM;
  assign sep_mm = range_long ? LONG_SEP_MM : SHORT_SEP_MM;

  //==========================================================================
  // Button hold timing
  logic btn_prev_ff;
  logic [HW-1:0] hold_ff;
  logic rel;

  assign rel = btn_prev_ff & ~button;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      btn_prev_ff <= 1'b0;
      hold_ff <= '0;
    end else begin
      btn_prev_ff <= button;
      if (!button) begin
        hold_ff <= '0;
      end else if (ms_tick && hold_ff != '1) begin
        hold_ff <= hold_ff + 14'h0001;
      end
    end
  end

  function automatic logic hit(input logic [HW-1:0] x);
    return button && ms_tick && (hold_ff == x - 14'h0001);
  endfunction : hit

  function automatic hold_cls_t cls(input logic [HW-1:0] h);
    if (h < TEACH_MS) begin
      return HC_SHORT;
    end else if (h < WIN_MS) begin
      return HC_ONE;
    end else if (h < FLIP_MS) begin
      return HC_WIN;
    end
    return HC_LONG;
  endfunction : cls

  //==========================================================================
  // Latest measurement
  logic [DW-1:0] cur_d_ff;
  logic cur_ok_ff;
  logic active;
  logic meas_upd;

  // A passive sensor ignores echoes so its outputs stay frozen
  assign meas_upd = meas_valid & active;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_d_ff <= '0;
      cur_ok_ff <= 1'b0;
    end else if (meas_upd) begin
      cur_d_ff <= meas_dist;
      cur_ok_ff <= meas_ok;
    end
  end

  function automatic logic in_rng(input logic [DW-1:0] d);
    return cur_ok_ff && d >= low_mm && d <= end_mm;
  endfunction : in_rng

  //==========================================================================
  // Teach state machine
  teach_st_t st_ff;
  teach_st_t nxt_st;
  logic sel_ff;
  logic nxt_sel;
  logic ign_ff;
  logic nxt_ign;
  logic [DW-1:0] p1_ff;
  logic [HW-1:0] tmr_ff;
  logic [DW-1:0] gap;
  logic ev_load;
  logic ev_fact;
  logic ev_one;
  logic ev_win1;
  logic ev_win2;
  logic ev_flip;

  assign gap = (p1_ff > cur_d_ff) ? p1_ff - cur_d_ff : cur_d_ff - p1_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_sel = sel_ff;
    nxt_ign = button ? ign_ff : 1'b0;
    ev_load = 1'b0;
    ev_fact = 1'b0;
    ev_one = 1'b0;
    ev_win1 = 1'b0;
    ev_win2 = 1'b0;
    ev_flip = 1'b0;
    case (st_ff)
      ST_INIT: begin
        ev_load = nvm_valid;
        ev_fact = ~nvm_valid;
        nxt_st = ST_POR;
      end
      ST_POR: begin
        if (!button) begin
          nxt_st = ST_RUN;
          if (rel && hold_ff > FACT_MS) begin
            ev_fact = 1'b1;
            nxt_st = ST_FACT;
          end
        end
      end
      ST_RUN: begin
        if (hit(TEACH_MS)) begin
          nxt_st = ST_SEL;
          nxt_sel = 1'b0;
          nxt_ign = 1'b1;
        end
      end
      ST_SEL, ST_ERR: begin
        if (!ign_ff && hit(FLIP_MS + 14'h0001)) begin
          ev_flip = 1'b1;
          nxt_st = ST_FLIP;
        end else if (!ign_ff && rel) begin
          case (cls(hold_ff))
            HC_SHORT: begin
              nxt_sel = ~sel_ff;
            end
            HC_ONE: begin
              if (in_rng(cur_d_ff)) begin
                ev_one = 1'b1;
                nxt_st = ST_RUN;
              end else begin
                nxt_st = ST_ERR;
              end
            end
            HC_WIN: begin
              if (in_rng(cur_d_ff)) begin
                ev_win1 = 1'b1;
                nxt_st = ST_WIN;
              end else begin
                nxt_st = ST_ERR;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_WIN: begin
        if (rel && cls(hold_ff) == HC_SHORT) begin
          if (in_rng(cur_d_ff) && gap >= sep_mm) begin
            ev_win2 = 1'b1;
            nxt_st = ST_RUN;
          end else begin
            nxt_st = ST_ERR;
          end
        end
      end
      ST_FLIP: begin
        if (!button && tmr_ff == SHOW_MS) begin
          nxt_st = ST_RUN;
        end
      end
      ST_FACT: begin
        if (tmr_ff == FACT_SHOW_MS) begin
          nxt_st = ST_RUN;
        end
      end
      default: begin
        nxt_st = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_INIT;
      sel_ff <= 1'b0;
      ign_ff <= 1'b0;
      p1_ff <= '0;
      tmr_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      sel_ff <= nxt_sel;
      ign_ff <= nxt_ign;
      if (ev_win1) begin
        p1_ff <= cur_d_ff;
      end
      if (nxt_st != st_ff) begin
        tmr_ff <= '0;
      end else if (ms_tick && ((st_ff == ST_FLIP && !button) ||
                               st_ff == ST_FACT)) begin
        tmr_ff <= tmr_ff + 14'h0001;
      end
    end
  end

  //==========================================================================
  // Stored switching points and functions
  logic [DW-1:0] lo_ff [2];
  logic [DW-1:0] hi_ff [2];
  logic [1:0] win_ff;
  logic [1:0] nc_ff;
  logic save_req_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        lo_ff[i] <= '0;
        hi_ff[i] <= SHORT_END_MM;
      end
      win_ff <= 2'h0;
      nc_ff <= NC_DEFAULT;
      save_req_ff <= 1'b0;
    end else begin
      save_req_ff <= ev_fact | ev_one | ev_win2 | ev_flip;
      if (ev_load) begin
        for (int i = 0; i < 2; i++) begin
          lo_ff[i] <= nvm_rd_data[24*i+13 +: DW];
          hi_ff[i] <= nvm_rd_data[24*i+2 +: DW];
          win_ff[i] <= nvm_rd_data[24*i+1];
          nc_ff[i] <= nvm_rd_data[24*i];
        end
      end else if (ev_fact) begin
        for (int i = 0; i < 2; i++) begin
          lo_ff[i] <= '0;
          hi_ff[i] <= end_mm;
        end
        win_ff <= 2'h0;
        nc_ff <= NC_DEFAULT;
      end else if (ev_one) begin
        lo_ff[sel_ff] <= '0;
        hi_ff[sel_ff] <= cur_d_ff;
        win_ff[sel_ff] <= 1'b0;
      end else if (ev_win2) begin
        lo_ff[sel_ff] <= (p1_ff < cur_d_ff) ? p1_ff : cur_d_ff;
        hi_ff[sel_ff] <= (p1_ff < cur_d_ff) ? cur_d_ff : p1_ff;
        win_ff[sel_ff] <= 1'b1;
      end else if (ev_flip) begin
        nc_ff[sel_ff] <= ~nc_ff[sel_ff];
      end
    end
  end

  // Storage write is one cycle after the change so the copy is settled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nvm_wr <= 1'b0;
      nvm_wr_data <= '0;
    end else begin
      nvm_wr <= save_req_ff;
      if (save_req_ff) begin
        for (int i = 0; i < 2; i++) begin
          nvm_wr_data[24*i +: 24] <= {lo_ff[i], hi_ff[i], win_ff[i], nc_ff[i]};
        end
      end
    end
  end

  //==========================================================================
  // Switching outputs
  logic [1:0] out_ff;
  logic [1:0] freeze;

  function automatic logic det(input logic [DW-1:0] d,
                               input logic [DW-1:0] lo,
                               input logic [DW-1:0] hi,
                               input logic win);
    return win ? (d >= lo && d <= hi) : (d <= hi);
  endfunction : det

  always_comb begin
    freeze = 2'h0;
    if (st_ff == ST_FLIP ||
        ((st_ff == ST_SEL || st_ff == ST_ERR) && button)) begin
      freeze[sel_ff] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_ff <= NC_DEFAULT;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ev_flip && sel_ff == 1'(i)) begin
          out_ff[i] <= ~out_ff[i];
        end else if (meas_upd && !freeze[i]) begin
          out_ff[i] <= (meas_ok &&
                        det(meas_dist, lo_ff[i], hi_ff[i], win_ff[i])) ^
                       nc_ff[i];
        end
      end
    end
  end

  assign first_switch_output = out_ff[0];
  assign second_switch_output = out_ff[1];

  //==========================================================================
  // Indicators
  logic [1:0] nxt_ind;
  logic nxt_green;
  logic v;
  logic alt;

  always_comb begin
    nxt_ind = 2'h0;
    nxt_green = 1'b0;
    v = 1'b0;
    alt = 1'b0;
    case (st_ff)
      ST_SEL: begin
        alt = button && !ign_ff && cls(hold_ff) >= HC_WIN;
        v = blink[BL_SLOW];
      end
      ST_ERR: begin
        alt = button && !ign_ff && cls(hold_ff) >= HC_WIN;
        v = blink[BL_FAST];
        nxt_green = blink[BL_FAST];
      end
      ST_WIN: begin
        alt = 1'b1;
      end
      ST_FLIP: begin
        alt = button;
        v = ~nc_ff[sel_ff];
      end
      default: begin
      end
    endcase
    if (alt) begin
      v = blink[BL_MID];
      nxt_green = ~blink[BL_MID];
    end
    nxt_ind[sel_ff] = v;
    if (st_ff == ST_FACT) begin
      nxt_ind = {2{blink[BL_FAST]}};
      nxt_green = ~blink[BL_FAST];
    end else if (st_ff == ST_RUN || st_ff == ST_POR || st_ff == ST_INIT) begin
      nxt_ind = out_ff;
      nxt_green = cur_ok_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led_yellow <= 1'b0;
      led_blue <= 1'b0;
      led_green <= 1'b0;
    end else begin
      led_yellow <= nxt_ind[0];
      led_blue <= nxt_ind[1];
      led_green <= nxt_green;
    end
  end

  //==========================================================================
  // Transmit scheduling on the shared line (low is asserted)
  logic [PW-1:0] pc_ff;
  logic [PW-1:0] end_cnt;
  logic [PW-1:0] fire_pt;
  logic line_prev_ff;
  logic line_fall;
  logic pull;

  assign line_fall = line_prev_ff & ~shared_pulse_coord_line_in;

  always_comb begin
    end_cnt = MEAS_MS - 8'h01;
    fire_pt = 8'h00;
    pull = 1'b0;
    case (mode)
      MODE_SYNC: begin
        end_cnt = SYNC_DLY_MS + MEAS_MS - 8'h01;
        fire_pt = SYNC_DLY_MS;
        pull = ms_tick && pc_ff == end_cnt;
      end
      MODE_MUX: begin
        end_cnt = PW'(net) * MEAS_MS + MUX_GUARD_MS - 8'h01;
        fire_pt = PW'(slot) * MEAS_MS;
        pull = ms_tick && pc_ff == end_cnt && slot == 2'h0;
      end
      default: begin
      end
    endcase
  end

  // In multiplex mode only the own slot is an active phase
  assign active = (mode != MODE_MUX) ||
                  (pc_ff >= fire_pt && pc_ff < fire_pt + MEAS_MS);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_ff <= '0;
      line_prev_ff <= 1'b1;
      tx_fire <= 1'b0;
      shared_pulse_coord_line_oe <= 1'b0;
      shared_pulse_coord_line_out <= 1'b0;
    end else begin
      line_prev_ff <= shared_pulse_coord_line_in;
      shared_pulse_coord_line_out <= 1'b0;
      tx_fire <= ms_tick && pc_ff == fire_pt;
      if (mode != MODE_ALONE && line_fall) begin
        pc_ff <= '0;
      end else if (ms_tick) begin
        pc_ff <= (pc_ff == end_cnt) ? '0 : pc_ff + 8'h01;
      end
      if (pull) begin
        shared_pulse_coord_line_oe <= 1'b1;
      end else if (ms_tick) begin
        shared_pulse_coord_line_oe <= 1'b0;
      end
    end
  end

  //==========================================================================
  // Register read port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {24'h00_0000, ctrl_ff};
        REG_STAT: reg_rdata <= {16'h0000, st_ff, 1'b0, sel_ff,
                                out_ff, win_ff, nc_ff};
        REG_PT1: reg_rdata <= {5'h00, hi_ff[0], 5'h00, lo_ff[0]};
        REG_PT2: reg_rdata <= {5'h00, hi_ff[1], 5'h00, lo_ff[1]};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : teach_output_ctrl

/* sim/teach_output_ctrl_properties.sv */
// Port assertions of the teach and output control block
`timescale 1ns/1ps
module teach_output_ctrl_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [teach_cfg_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_fire,
  input wire logic nvm_wr,
  input wire logic [teach_cfg_pkg::NVW-1:0] nvm_wr_data,
  input wire logic first_switch_output,
  input wire logic second_switch_output,
  input wire logic shared_pulse_coord_line_out,
  input wire logic shared_pulse_coord_line_oe
);
  import teach_cfg_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  //==========================================================================
  // Register answers
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_RD_HOLE: assert property (reg_rd && reg_addr[1:0] != 2'h0
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  //==========================================================================
  // Outputs, storage and shared wire
  AST_FACT_FUNC: assert property ($fell(rst) |->
    !first_switch_output && second_switch_output)
    else $error("output function defaults wrong");
  AST_FIRE_GAP: assert property (tx_fire |=> !tx_fire [*8])
    else $error("transmit pulses too close");
  AST_LINE_LOW: assert property (shared_pulse_coord_line_out == 1'b0)
    else $error("shared wire driven high");
  // Open-drain pull lasts about one ms, never stuck low
  AST_OE_PULL: assert property ($rose(shared_pulse_coord_line_oe)
    |=> shared_pulse_coord_line_oe ##[1:4] !shared_pulse_coord_line_oe)
    else $error("shared wire pull length wrong");
  AST_NVM_PULSE: assert property (nvm_wr |=> !nvm_wr)
    else $error("storage write not a pulse");
  AST_NVM_HOLD: assert property (nvm_wr |=> $stable(nvm_wr_data) [*4])
    else $error("storage data moved after write");
  cover property (tx_fire);
  cover property (nvm_wr);
  cover property ($rose(shared_pulse_coord_line_oe));
endmodule : teach_output_ctrl_properties

bind teach_output_ctrl teach_output_ctrl_properties i_props (.*);

/* sim/usr.sv */
// Model of the button operator, target object and shared wire
`timescale 1ns/1ps
module usr (
  input wire logic mclk,
  input wire logic shared_pulse_coord_line_oe,
  output logic button,
  output logic meas_valid,
  output logic meas_ok,
  output logic [teach_cfg_pkg::DW-1:0] meas_dist,
  output logic shared_pulse_coord_line_in
);
  import teach_cfg_pkg::*;
  logic [5:0] cnt = 6'h00;
  initial begin
    button = 1'b0;
    meas_valid = 1'b0;
    meas_ok = 1'b1;
    meas_dist = SHORT_END_MM;
  end
  // Wire has a pull-up, so a released line reads high
  assign shared_pulse_coord_line_in = ~shared_pulse_coord_line_oe;
  always @(posedge mclk) begin
    cnt <= cnt + 6'h01;
    meas_valid <= (cnt == 6'h00);
  end
  // Object stays put between echoes, which come every 64 cycles; distance is the caller's choice
  task automatic place(input logic [DW-1:0] d);
    meas_dist <= d;
  endtask : place
  // Hold in ms at two cycles per ms, then let the block settle
  task automatic press(input int ms);
    button <= 1'b1;
    repeat (2 * ms) @(posedge mclk);
    button <= 1'b0;
    repeat (400) @(posedge mclk);
  endtask : press
  // Echo lost or found, e.g. object out of the beam
  task automatic echo(input logic ok);
    meas_ok <= ok;
  endtask : echo
endmodule : usr

/* sim/teach_output_ctrl_test.sv */
// Self-checking bench of the teach and output control block
`timescale 1ns/1ps
module teach_output_ctrl_test;
  import teach_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nvm_valid = 1'b0;
  logic [NVW-1:0] nvm_rd_data = '0;
  logic [AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [31:0] reg_rdata;
  logic [DW-1:0] meas_dist;
  logic [NVW-1:0] nvm_wr_data;
  logic button, meas_valid, meas_ok, tx_fire, nvm_wr, was;
  logic first_switch_output, second_switch_output;
  logic led_yellow, led_blue, led_green;
  logic shared_pulse_coord_line_in, shared_pulse_coord_line_out;
  logic shared_pulse_coord_line_oe;
  int errors = 0;
  int n_tests = 0;
  int n_nvm = 0;
  int ty, tb2, eq, n_oe, n_fire;
  // Two cycles per ms keeps the twelve second holds affordable
  teach_output_ctrl #(.CYC_PER_MS(2)) i_teach_output_ctrl (.*);
  usr i_usr (.*);
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) n_nvm += int'(nvm_wr === 1'b1);
  //==========================================================================
  // Tasks
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string s);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(s, e, reg_rdata & m);
  endtask : rdc
  // Counts LED edges over 1.2 s and cycles where green equals yellow
  task automatic watch;
    logic y;
    logic b;
    ty = 0;
    tb2 = 0;
    eq = 0;
    for (int i = 0; i < 2400; i++) begin
      y = led_yellow;
      b = led_blue;
      @(posedge mclk);
      ty += int'(led_yellow !== y);
      tb2 += int'(led_blue !== b);
      eq += int'(led_green === led_yellow);
    end
  endtask : watch
  task automatic finish_test;
    $display("Checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  //==========================================================================
  // Sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc(4'h2, '1, 32'h0, "unmapped");
    rdc(REG_STAT, 32'hFF03, 32'h0402, "stat");
    rdc(REG_PT1, 32'h07FF0000, 32'h01900000, "pt1");
    n_fire = n_nvm;
    i_usr.press(2100);
    watch();
    chk("yellow", 1, 32'(ty >= 2 && ty <= 3));
    chk("blue", 0, 32'(tb2));
    i_usr.press(500);
    watch();
    chk("blue", 1, 32'(tb2 >= 2 && tb2 <= 3));
    rdc(REG_STAT, 32'hFF40, 32'h0840, "sel");
    i_usr.press(500);
    i_usr.place(11'h0C8);
    i_usr.press(3000);
    rdc(REG_PT1, 32'hFFFF0000, 32'h00C80000, "pt1");
    chk("nvm", 1, 32'(n_nvm - n_fire));
    i_usr.press(2100);
    i_usr.place(11'h064);
    i_usr.press(8000);
    watch();
    chk("alternate", 0, 32'(eq));
    chk("3 Hz", 1, 32'(ty >= 6 && ty <= 8));
    i_usr.place(11'h12C);
    i_usr.press(500);
    rdc(REG_PT1, 32'h07FF07FF, 32'h012C0064, "window");
    i_usr.press(2100);
    i_usr.press(8000);
    i_usr.place(11'h118);
    i_usr.press(500);
    watch();
    chk("together", 2400, 32'(eq));
    chk("8 Hz", 1, 32'(ty >= 18 && ty <= 20));
    was = first_switch_output;
    i_usr.press(12500);
    rdc(REG_STAT, 32'hFF03, 32'h2003, "flip");
    chk("output", {31'h0, ~was}, {31'h0, first_switch_output});
    chk("nc led", 0, {31'h0, led_yellow});
    reg_addr <= REG_CTRL;
    reg_wdata <= 32'h21;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    n_oe = 0;
    n_fire = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      n_oe += int'(shared_pulse_coord_line_oe === 1'b1);
      n_fire += int'(tx_fire === 1'b1);
    end
    chk("pull", 1, 32'(n_oe > 0));
    chk("fire", 1, 32'(n_fire > 0));
    reg_wdata <= 32'h62;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    n_fire = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      n_fire += int'(tx_fire === 1'b1);
    end
    chk("mux fire", 1, 32'(n_fire));
    nvm_valid <= 1'b1;
    nvm_rd_data <= 48'h0C84_B200_0321;
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc(REG_STAT, 32'hFF0F, 32'h0409, "load");
    rdc(REG_PT2, '1, 32'h012C0064, "pt2");
    repeat (70) @(posedge mclk);
    chk("first_switch_output", 1, {31'h0, first_switch_output});
    i_usr.echo(1'b0);
    repeat (70) @(posedge mclk);
    chk("no echo", 0, {31'h0, second_switch_output});
    finish_test();
  end
endmodule : teach_output_ctrl_test
